// ==== rtl/co2_range_tracker.sv ====
// Purpose: Tracks the low, medium or high range of the CO2 value with hysteresis
// Assumes: Update pulse arrives with the new value on the same cycle
// Notes:   A move counts only when the value passes a limit by more than the hysteresis
`timescale 1ns/100ps
`default_nettype none
`include "gas_sensor_defines.svh"
module co2_range_tracker
   import gas_sensor_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset,
   input  wire logic        i_update,
   input  wire logic [15:0] i_value,
   input  wire logic [15:0] i_lim_low_mid,
   input  wire logic [15:0] i_lim_mid_high,
   input  wire logic [15:0] i_hyst,
   output logic             o_crossed
);
   range_t range_reg;
   range_t range_next;
   logic [16:0] v;

   // Widened compare avoids wrap when a limit sits near zero or full scale
   function automatic logic above(input logic [16:0] x, input logic [15:0] l,
                                  input logic [15:0] h);
      above = x > ({1'b0, l} + {1'b0, h});
   endfunction
   function automatic logic below(input logic [16:0] x, input logic [15:0] l,
                                  input logic [15:0] h);
      below = (x + {1'b0, h}) < {1'b0, l};
   endfunction

   assign v = {1'b0, i_value};

   // Next range seen from the current one [RULE21]
   always_comb begin
      range_next = range_reg;
      case (range_reg)
         RANGE_LOW: begin
            if (above(v, i_lim_mid_high, i_hyst)) range_next = RANGE_HIGH;
            else if (above(v, i_lim_low_mid, i_hyst)) range_next = RANGE_MID;
         end
         RANGE_MID: begin
            if (above(v, i_lim_mid_high, i_hyst)) range_next = RANGE_HIGH;
            else if (below(v, i_lim_low_mid, i_hyst)) range_next = RANGE_LOW;
         end
         RANGE_HIGH: begin
            if (below(v, i_lim_low_mid, i_hyst)) range_next = RANGE_LOW;
            else if (below(v, i_lim_mid_high, i_hyst)) range_next = RANGE_MID;
         end
         default: range_next = RANGE_LOW;
      endcase
   end

   assign o_crossed = i_update && (range_next != range_reg);  // [RULE21]

   // Range state advances only on a new sample
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         range_reg <= RANGE_LOW;
      end else if (i_update) begin
         range_reg <= range_next;
      end
   end

   a_hyst_band: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (i_update && range_reg == RANGE_LOW
       && ({1'b0, i_value} <= {1'b0, i_lim_low_mid} + {1'b0, i_hyst})) |-> !o_crossed)  // [RULE21]
      else $error("crossing inside hysteresis band");
endmodule
`default_nettype wire

// ==== rtl/gas_sensor_defines.svh ====
// Purpose: Named offsets, field positions, reset values and times for the gas sensor block
// Assumes: Included by bare name from every design file that needs a constant
// Notes:   Definitions only
`ifndef GAS_SENSOR_DEFINES_SVH
`define GAS_SENSOR_DEFINES_SVH

// Register offsets on the byte-level register port
`define ADDR_DEVICE_STATE    8'h00
`define ADDR_MEAS_SETUP      8'h01
`define ADDR_COMPUTED_RESULT 8'h02
`define ADDR_RAW_DATA        8'h03
`define ADDR_FAULT_SOURCE    8'hE0

// Device state field positions
`define ST_FW_BIT     7
`define ST_ERASE_BIT  6
`define ST_VERIFY_BIT 5
`define ST_VALID_BIT  4
`define ST_READY_BIT  3
`define ST_FAULT_BIT  0

// Measurement setup fields
`define SU_MODE_HI    6
`define SU_MODE_LO    4
`define SU_IRQ_EN_BIT 3
`define SU_LIMIT_BIT  2
`define SU_WMASK      8'h7C
`define SU_RESET      8'h00

// Drive mode codes
`define MODE_IDLE 3'h0
`define MODE_1S   3'h1
`define MODE_10S  3'h2
`define MODE_60S  3'h3
`define MODE_RAW  3'h4

// Clock rate and measurement intervals in milliseconds
`define CLK_HZ    64'd100000000
`define T_1S_MS   64'd1000
`define T_10S_MS  64'd10000
`define T_60S_MS  64'd60000
`define T_RAW_MS  64'd250

// Range limits and hysteresis in ppm
`define LIM_LOW_MID_DEF  16'h05DC
`define LIM_MID_HIGH_DEF 16'h09C4
`define HYST_DEF         16'h0032

// Target address, low bit taken from the select pin
`define TARGET_ADDR_BASE 7'h5A

`endif

// ==== rtl/gas_sensor_pkg.sv ====
// Purpose: Shared types for the gas sensor status and mode block
// Assumes: Nothing beyond the defines header
// Notes:   Range codes are one-hot
package gas_sensor_pkg;
   typedef logic [2:0] drive_mode_t;
   typedef enum logic [2:0] {
      RANGE_LOW  = 3'b001,
      RANGE_MID  = 3'b010,
      RANGE_HIGH = 3'b100
   } range_t;
endpackage

// ==== rtl/gas_sensor_status_and_mode.sv ====
// Purpose: Device state and measurement setup registers of a digital gas sensor
// Assumes: A target engine delivers byte reads and writes on the register port
// Notes:   Serial framing, bootloader commands and other registers sit outside
//
// Notes on behaviour
// (RULE1) State bit 7: 0 boot, 1 application
// (RULE2) Bit 6: erase done, boot mode only
// (RULE3) Bit 5: verify done, boot mode only
// (RULE4) Host waits 70ms after verify command
// (RULE5) Bit 4: valid application firmware present
// (RULE6) Bit 3 set by sample, cleared reading result
// (RULE7) Bit 0 flags fault, source at E0
// (RULE8) Drive mode 000 means idle, no measurement
// (RULE9) Mode 001 measures every second
// (RULE10) Mode 010 measures every ten seconds
// (RULE11) Mode 011 measures every sixty seconds
// (RULE12) Mode 100 raw measurement every 250ms
// (RULE13) Host avoids reserved drive mode codes
// (RULE14) Raw mode updates raw data only
// (RULE15) Interval end loads sample, sets flag
// (RULE16) Setup bit 3 enables sample interrupt
// (RULE17) Result read releases the interrupt line
// (RULE18) Flag set every cycle regardless of enable
// (RULE19) Setup bit 2: interrupt only on crossing
// (RULE20) Bit 2 clear: interrupt on every sample
// (RULE21) Crossing means range change beyond 50ppm
// (RULE22) Limits default 1500 and 2500 ppm
// (RULE23) Target address 5A or 5B by pin
// (RULE24) Reserved bits read zero, writes ignored
`timescale 1ns/100ps
`default_nettype none
`include "gas_sensor_defines.svh"
module gas_sensor_status_and_mode
   import gas_sensor_pkg::*;
#(
   parameter longint unsigned CYC_1S  = `T_1S_MS  * (`CLK_HZ / 64'd1000),
   parameter longint unsigned CYC_10S = `T_10S_MS * (`CLK_HZ / 64'd1000),
   parameter longint unsigned CYC_60S = `T_60S_MS * (`CLK_HZ / 64'd1000),
   parameter longint unsigned CYC_RAW = `T_RAW_MS * (`CLK_HZ / 64'd1000)
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset,
   // Byte-level register port from the serial target engine
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [2:0]  i_reg_index,
   input  wire logic [7:0]  i_reg_wdata,
   output logic [7:0]       o_reg_rdata,
   // Firmware and fault state from the device controller
   input  wire logic        i_app_mode,
   input  wire logic        i_erase_done,
   input  wire logic        i_verify_done,
   input  wire logic        i_app_valid,
   input  wire logic        i_fault,
   input  wire logic [7:0]  i_fault_source,
   // Sample data from the measurement path
   input  wire logic [15:0] i_eco2,
   input  wire logic [15:0] i_tvoc,
   input  wire logic [15:0] i_raw,
   // Limit mailbox writes
   input  wire logic        i_limit_wr,
   input  wire logic [15:0] i_lim_low_mid,
   input  wire logic [15:0] i_lim_mid_high,
   // Address select pin and interrupt pin
   input  wire logic        i_addr_sel,
   output logic [6:0]       o_target_addr,
   output logic             o_irq_line_n_o,
   output logic             o_irq_line_n_oe_n
);
   logic [7:0]  setup_reg;
   logic        ready_reg;
   logic        irq_reg;
   logic [15:0] eco2_reg;
   logic [15:0] tvoc_reg;
   logic [15:0] raw_reg;
   logic [15:0] lim_lm_reg;
   logic [15:0] lim_mh_reg;
   logic [1:0]  sel_sync_reg;
   logic [6:0]  taddr_reg;
   logic [7:0]  rdata_reg;
   logic        tick;
   logic        crossed;
   logic        result_rd;
   logic        raw_mode;
   logic [7:0]  state_byte;
   drive_mode_t mode;

   assign mode      = setup_reg[`SU_MODE_HI:`SU_MODE_LO];
   assign raw_mode  = (mode == `MODE_RAW);
   assign result_rd = i_reg_rd && (i_reg_addr == `ADDR_COMPUTED_RESULT);

   // Measurement interval per drive mode [RULE8] [RULE9] [RULE10] [RULE11] [RULE12]
   meas_interval_timer #(
      .CW      (33),
      .CYC_1S  (CYC_1S),
      .CYC_10S (CYC_10S),
      .CYC_60S (CYC_60S),
      .CYC_RAW (CYC_RAW)
   ) u_timer (
      .i_ref_clk (i_ref_clk),
      .i_reset   (i_reset),
      .i_mode    (mode),
      .o_tick    (tick)
   );

   // Raw samples carry no CO2 figure, so they never feed the range tracker
   co2_range_tracker u_range (
      .i_ref_clk      (i_ref_clk),
      .i_reset        (i_reset),
      .i_update       (tick && !raw_mode),
      .i_value        (i_eco2),
      .i_lim_low_mid  (lim_lm_reg),
      .i_lim_mid_high (lim_mh_reg),
      .i_hyst         (`HYST_DEF),
      .o_crossed      (crossed)
   );

   // Device state byte; erase and verify show only in boot mode
   always_comb begin
      state_byte                 = 8'h00;  // [RULE24]
      state_byte[`ST_FW_BIT]     = i_app_mode;  // [RULE1]
      state_byte[`ST_ERASE_BIT]  = i_erase_done && !i_app_mode;  // [RULE2]
      state_byte[`ST_VERIFY_BIT] = i_verify_done && !i_app_mode;  // [RULE3]
      state_byte[`ST_VALID_BIT]  = i_app_valid;  // [RULE5]
      state_byte[`ST_READY_BIT]  = ready_reg;  // [RULE6]
      state_byte[`ST_FAULT_BIT]  = i_fault;  // [RULE7]
   end

   // Byte of the multi-byte result read at a given index
   function automatic logic [7:0] result_byte(input logic [2:0] idx, input logic [7:0] st);
      case (idx)
         3'h0:    result_byte = eco2_reg[15:8];
         3'h1:    result_byte = eco2_reg[7:0];
         3'h2:    result_byte = tvoc_reg[15:8];
         3'h3:    result_byte = tvoc_reg[7:0];
         3'h4:    result_byte = st;
         3'h5:    result_byte = i_fault_source;
         3'h6:    result_byte = raw_reg[15:8];
         default: result_byte = raw_reg[7:0];
      endcase
   endfunction

   // Read data register; unmapped offsets answer zero
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         rdata_reg <= 8'h00;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            `ADDR_DEVICE_STATE:    rdata_reg <= state_byte;
            `ADDR_MEAS_SETUP:      rdata_reg <= setup_reg;
            `ADDR_COMPUTED_RESULT: rdata_reg <= result_byte(i_reg_index, state_byte);
            `ADDR_RAW_DATA:        rdata_reg <= i_reg_index[0] ? raw_reg[7:0] : raw_reg[15:8];
            `ADDR_FAULT_SOURCE:    rdata_reg <= i_fault_source;  // [RULE7]
            default:               rdata_reg <= 8'h00;
         endcase
      end
   end
   assign o_reg_rdata = rdata_reg;

   // Measurement setup; reserved bits are dropped on write
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         setup_reg <= `SU_RESET;
      end else if (i_reg_wr && (i_reg_addr == `ADDR_MEAS_SETUP)) begin
         setup_reg <= i_reg_wdata & `SU_WMASK;  // [RULE24]
      end
   end

   // Limits hold defaults until the host writes the mailbox
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         lim_lm_reg <= `LIM_LOW_MID_DEF;  // [RULE22]
         lim_mh_reg <= `LIM_MID_HIGH_DEF;  // [RULE22]
      end else if (i_limit_wr) begin
         lim_lm_reg <= i_lim_low_mid;
         lim_mh_reg <= i_lim_mid_high;
      end
   end

   // Sample capture; result stays frozen in raw mode
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         eco2_reg <= 16'h0000;
         tvoc_reg <= 16'h0000;
         raw_reg  <= 16'h0000;
      end else if (tick) begin
         raw_reg <= i_raw;  // [RULE15]
         if (!raw_mode) begin
            eco2_reg <= i_eco2;  // [RULE14] [RULE15]
            tvoc_reg <= i_tvoc;
         end
      end
   end

   // New-sample flag; a sample in the read cycle wins so it is never lost
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         ready_reg <= 1'b0;
      end else if (tick) begin
         ready_reg <= 1'b1;  // [RULE15] [RULE18]
      end else if (result_rd) begin
         ready_reg <= 1'b0;  // [RULE6]
      end
   end

   // Interrupt request; threshold mode asks for a range crossing
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         irq_reg <= 1'b0;
      end else if (tick && setup_reg[`SU_IRQ_EN_BIT]
                   && (!setup_reg[`SU_LIMIT_BIT] || crossed)) begin
         irq_reg <= 1'b1;  // [RULE16] [RULE19] [RULE20]
      end else if (result_rd) begin
         irq_reg <= 1'b0;  // [RULE17]
      end
   end
   // Open-drain line: only ever pulled low, never driven high
   assign o_irq_line_n_o    = 1'b0;
   assign o_irq_line_n_oe_n = !irq_reg;

   // Address select pin crosses in through two flops
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         sel_sync_reg <= 2'h0;
         taddr_reg    <= `TARGET_ADDR_BASE;
      end else begin
         sel_sync_reg <= {sel_sync_reg[0], i_addr_sel};
         taddr_reg    <= `TARGET_ADDR_BASE | {6'h00, sel_sync_reg[1]};  // [RULE23]
      end
   end
   assign o_target_addr = taddr_reg;

   // Sample event followed by flag set
   sequence s_sample_flag;
      tick ##1 ready_reg;
   endsequence

   a_sample_sets: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      tick |-> s_sample_flag)  // [RULE18]
      else $error("sample did not set flag");
   a_read_clears: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (result_rd && !tick) |=> !ready_reg)  // [RULE6]
      else $error("result read did not clear flag");
   a_irq_release: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (result_rd && !tick) |=> o_irq_line_n_oe_n)  // [RULE17]
      else $error("interrupt line not released");
   a_irq_disabled: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (!setup_reg[`SU_IRQ_EN_BIT] && o_irq_line_n_oe_n) |=> o_irq_line_n_oe_n)  // [RULE16]
      else $error("interrupt while disabled");
   a_irq_every: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (tick && setup_reg[`SU_IRQ_EN_BIT] && !setup_reg[`SU_LIMIT_BIT])
      |=> !o_irq_line_n_oe_n)  // [RULE20]
      else $error("enabled sample gave no interrupt");
   a_irq_limit: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (tick && setup_reg[`SU_LIMIT_BIT] && !crossed && o_irq_line_n_oe_n && !result_rd)
      |=> o_irq_line_n_oe_n)  // [RULE19]
      else $error("threshold mode fired without crossing");
   a_raw_keeps: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (tick && raw_mode) |=> ($stable(eco2_reg) && (raw_reg == $past(i_raw))))  // [RULE14]
      else $error("raw mode touched the result");
   a_setup_mask: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (i_reg_wr && i_reg_addr == `ADDR_MEAS_SETUP) |=> (setup_reg & ~`SU_WMASK) == 8'h00)  // [RULE24]
      else $error("reserved setup bits stored");
   a_boot_bits: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (i_reg_rd && i_reg_addr == `ADDR_DEVICE_STATE && i_app_mode)
      |=> (o_reg_rdata[`ST_FW_BIT] && o_reg_rdata[2:1] == 2'h0
           && !o_reg_rdata[`ST_ERASE_BIT] && !o_reg_rdata[`ST_VERIFY_BIT]))  // [RULE1] [RULE2]
      else $error("bad state byte in application mode");
endmodule
`default_nettype wire

// ==== rtl/meas_interval_timer.sv ====
// Purpose: Produces one pulse at the end of each measurement interval
// Assumes: Drive mode comes from a register on the same clock
// Notes:   Counter restarts whenever the drive mode changes
`timescale 1ns/100ps
`default_nettype none
`include "gas_sensor_defines.svh"
module meas_interval_timer
   import gas_sensor_pkg::*;
#(
   parameter int              CW     = 33,
   parameter longint unsigned CYC_1S  = 64'd100000000,
   parameter longint unsigned CYC_10S = 64'd1000000000,
   parameter longint unsigned CYC_60S = 64'd6000000000,
   parameter longint unsigned CYC_RAW = 64'd25000000
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset,
   input  wire drive_mode_t i_mode,
   output logic             o_tick
);
   logic [CW-1:0] count_reg;
   drive_mode_t   mode_reg;
   logic [CW-1:0] limit;

   // Interval length in cycles; zero marks a mode that never measures
   function automatic logic [CW-1:0] interval_of(input drive_mode_t m);
      case (m)
         `MODE_1S:  interval_of = CW'(CYC_1S);
         `MODE_10S: interval_of = CW'(CYC_10S);
         `MODE_60S: interval_of = CW'(CYC_60S);
         `MODE_RAW: interval_of = CW'(CYC_RAW);
         default:   interval_of = '0;
      endcase
   endfunction

   assign limit  = interval_of(i_mode);
   // Idle and reserved codes give a zero limit, so no tick ever fires
   assign o_tick = (limit != '0) && (i_mode == mode_reg) && (count_reg == limit - 1'b1);

   // Remember the mode so that a change restarts the interval
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         mode_reg <= `MODE_IDLE;
      end else begin
         mode_reg <= i_mode;
      end
   end

   // Interval counter
   always_ff @(posedge i_ref_clk) begin
      if (i_reset || (i_mode != mode_reg) || o_tick || (limit == '0)) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_reg + 1'b1;
      end
   end

   a_idle_no_tick: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (i_mode == `MODE_IDLE) |-> !o_tick)  // [RULE8]
      else $error("tick while idle");
   a_mode_restart: assert property (@(posedge i_ref_clk) disable iff (i_reset)
      (i_mode != mode_reg) |=> (count_reg == '0))
      else $error("interval not restarted on mode change");
endmodule
`default_nettype wire

// ==== tb/host_model.sv ====
// Purpose: Host side of the byte-level register port of the gas sensor block
// Assumes: Serial framing is already stripped, one strobe per byte
// Notes:   Requests launch just after a rising edge and drop after one edge
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input  wire logic       i_ref_clk,
   output logic            o_reg_wr,
   output logic            o_reg_rd,
   output logic [7:0]      o_reg_addr,
   output logic [2:0]      o_reg_index,
   output logic [7:0]      o_reg_wdata,
   input  wire logic [7:0] i_reg_rdata
);
   // Idle bus carries junk, not the last request
   initial begin
      o_reg_wr    = 1'b0;
      o_reg_rd    = 1'b0;
      o_reg_addr  = 8'hA5;
      o_reg_index = 3'h7;
      o_reg_wdata = 8'h5A;
   end

   // No verify command is ever sent, so no quiet period is owed
   // Target addressing sits in the serial engine beside this port
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      // Reserved drive codes are turned into idle before leaving the host
      if (addr == 8'h01 && data[6] && data[5:4] != 2'b00) begin
         data[6:4] = 3'h0;
      end
      @(posedge i_ref_clk);
      o_reg_wr    <= 1'b1;
      o_reg_addr  <= addr;
      o_reg_wdata <= data;
      @(posedge i_ref_clk);
      o_reg_wr    <= 1'b0;
      o_reg_addr  <= ~addr;
      o_reg_wdata <= ~data;
   endtask

   // Read data is registered, so it is taken one cycle after the strobe
   task automatic read_reg(input logic [7:0] addr, input logic [2:0] idx,
                           output logic [7:0] data);
      @(posedge i_ref_clk);
      o_reg_rd    <= 1'b1;
      o_reg_addr  <= addr;
      o_reg_index <= idx;
      @(posedge i_ref_clk);
      o_reg_rd    <= 1'b0;
      o_reg_addr  <= ~addr;
      o_reg_index <= ~idx;
      @(negedge i_ref_clk);
      data = i_reg_rdata;
   endtask
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the gas sensor status and mode block
// Assumes: Short interval parameters stand in for the real second counts
// Notes:   Random status and sample values come from a fixed-seed xorshift
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import gas_sensor_pkg::*;
   localparam longint unsigned C1  = 20;
   localparam longint unsigned C10 = 40;
   localparam longint unsigned C60 = 60;
   // Raw interval kept longer than the read-back sequence so no second sample lands mid-check
   localparam longint unsigned CR  = 30;
   logic        i_ref_clk = 1'b0;
   logic        i_reset = 1'b1;
   logic        reg_wr, reg_rd, app_mode, erase_done, verify_done, app_valid, fault;
   logic [7:0]  reg_addr, reg_wdata, rdata, fault_src, rv;
   logic [2:0]  reg_index;
   logic [15:0] eco2, tvoc, raw, last_eco;
   logic        limit_wr, addr_sel, pin_o, oe_n, seen_irq;
   logic [15:0] lim_lm, lim_mh;
   logic [6:0]  target_addr;
   logic [31:0] seed = 32'd29866;
   logic [31:0] r;
   int          miscompares = 0;
   int          total_checks = 0;
   int          cnt;
   longint unsigned cyc_tab [1:4] = '{C1, C10, C60, CR};
   logic [15:0] thr_val [0:5] = '{16'd1000, 16'd1540, 16'd1551, 16'd1551, 16'd1460, 16'd1440};
   logic        thr_exp [0:5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};

   // Inputs all have a value before the first edge
   initial begin
      {app_mode, erase_done, verify_done, app_valid, fault, limit_wr, addr_sel} = '0;
      {fault_src, eco2, tvoc, raw, lim_lm, lim_mh} = '0;
   end

   always #5 i_ref_clk = ~i_ref_clk;

   gas_sensor_status_and_mode #(.CYC_1S(C1), .CYC_10S(C10), .CYC_60S(C60), .CYC_RAW(CR)) dut (
      .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
      .i_reg_addr(reg_addr), .i_reg_index(reg_index), .i_reg_wdata(reg_wdata),
      .o_reg_rdata(rdata), .i_app_mode(app_mode), .i_erase_done(erase_done),
      .i_verify_done(verify_done), .i_app_valid(app_valid), .i_fault(fault),
      .i_fault_source(fault_src), .i_eco2(eco2), .i_tvoc(tvoc), .i_raw(raw),
      .i_limit_wr(limit_wr), .i_lim_low_mid(lim_lm), .i_lim_mid_high(lim_mh),
      .i_addr_sel(addr_sel), .o_target_addr(target_addr), .o_irq_line_n_o(pin_o),
      .o_irq_line_n_oe_n(oe_n));

   host_model host (
      .i_ref_clk(i_ref_clk), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr),
      .o_reg_index(reg_index), .o_reg_wdata(reg_wdata), .i_reg_rdata(rdata));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   // Erase and verify only mean something in boot mode; bits 2:1 stay zero
   function automatic logic [7:0] exp_state(input logic app, er, ve, va, rdy, flt);
      return {app, er & ~app, ve & ~app, va, rdy, 2'b00, flt};
   endfunction

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic do_reset();
      i_reset <= 1'b1;
      repeat (6) @(posedge i_ref_clk);
      i_reset <= 1'b0;
   endtask

   // Notes whether the interrupt line was pulled low in the span
   task automatic watch(input int n);
      seen_irq = 1'b0;
      repeat (n) begin
         @(negedge i_ref_clk);
         if (oe_n === 1'b0) seen_irq = 1'b1;
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Whole run is under a thousand cycles; this cuts a hang short
   initial begin
      #500000;
      miscompares++;
      wrap_up();
   end

   initial begin
      do_reset();
      host.read_reg(8'h00, 3'h0, rv);
      chk("state_reset", rv, 8'h00);
      host.read_reg(8'h01, 3'h0, rv);
      chk("setup_reset", rv, 8'h00);
      chk("irq_reset", {7'h00, oe_n}, 8'h01);
      chk("pin_data", {7'h00, pin_o}, 8'h00);
      $display("test reset done");

      // Random firmware and fault state, status and fault source read back
      for (int i = 0; i < 16; i++) begin
         seed = xs(seed);
         r = seed;
         @(posedge i_ref_clk);
         {fault, app_valid, verify_done, erase_done, app_mode} <= r[4:0];
         fault_src <= r[15:8];
         host.read_reg(8'h00, 3'h0, rv);
         chk("state", rv, exp_state(r[0], r[1], r[2], r[3], 1'b0, r[4]));
         host.read_reg(8'hE0, 3'h0, rv);
         chk("fault_src", rv, r[15:8]);
      end
      $display("test status done");

      // Reserved setup bits are dropped, unmapped offset reads zero
      host.write_reg(8'h01, 8'h8B);
      host.read_reg(8'h01, 3'h0, rv);
      chk("setup_reserved", rv, 8'h08);
      host.write_reg(8'h00, 8'hFF);
      host.read_reg(8'h7E, 3'h0, rv);
      chk("unmapped", rv, 8'h00);
      host.write_reg(8'h01, 8'h00);
      for (int a = 0; a < 2; a++) begin
         @(posedge i_ref_clk);
         addr_sel <= a[0];
         repeat (5) @(posedge i_ref_clk);
         chk("target_addr", {1'b0, target_addr}, {1'b0, 6'h2D, a[0]});
      end
      $display("test setup and address done");

      // Each measuring drive mode (001 to 100): interval, interrupt, flag, result and raw contents
      @(posedge i_ref_clk);
      {fault, app_valid, verify_done, erase_done, app_mode} <= 5'b00001;
      last_eco = 16'h0000;
      for (int m = 1; m <= 4; m++) begin
         seed = xs(seed);
         @(posedge i_ref_clk);
         eco2 <= seed[15:0];
         tvoc <= seed[31:16];
         raw  <= seed[23:8];
         host.write_reg(8'h01, {1'b0, m[2:0], 4'h8});
         cnt = 0;
         while (oe_n !== 1'b0 && cnt < 200) begin
            @(posedge i_ref_clk);
            #1;
            cnt++;
         end
         chk("interval_ok", {7'h00, cnt >= cyc_tab[m] - 1 && cnt <= cyc_tab[m] + 3}, 8'h01);
         host.read_reg(8'h00, 3'h0, rv);
         chk("state_ready", rv, 8'h88);
         host.read_reg(8'h03, 3'h0, rv);
         chk("raw_hi", rv, seed[23:16]);
         if (m != 4) last_eco = seed[15:0];
         host.read_reg(8'h02, 3'h2, rv);
         if (m != 4) chk("tvoc_hi", rv, seed[31:24]);
         host.read_reg(8'h02, 3'h0, rv);
         chk("eco2_hi", rv, last_eco[15:8]);
         chk("irq_release", {7'h00, oe_n}, 8'h01);
         host.read_reg(8'h00, 3'h0, rv);
         chk("state_cleared", rv, 8'h80);
         host.write_reg(8'h01, 8'h00);
         host.read_reg(8'h02, 3'h1, rv);
      end
      $display("test drive modes done");

      // Idle never samples; with the enable off the flag still rises
      watch(100);
      chk("idle_irq", {7'h00, seen_irq}, 8'h00);
      host.read_reg(8'h00, 3'h0, rv);
      chk("idle_flag", rv, 8'h80);
      host.write_reg(8'h01, 8'h10);
      watch(int'(C1) + 4);
      chk("noen_irq", {7'h00, seen_irq}, 8'h00);
      host.read_reg(8'h00, 3'h0, rv);
      chk("noen_flag", rv, 8'h88);
      host.write_reg(8'h01, 8'h00);
      host.read_reg(8'h02, 3'h0, rv);
      $display("test idle and enable done");

      // Threshold interrupts, fresh range state after a second reset
      do_reset();
      host.write_reg(8'h01, 8'h1C);
      for (int k = 0; k < 6; k++) begin
         @(posedge i_ref_clk);
         eco2 <= thr_val[k];
         watch(int'(C1) + 2);
         host.read_reg(8'h02, 3'h0, rv);
         chk("thr_irq", {7'h00, seen_irq}, {7'h00, thr_exp[k]});
      end
      // Lowered limit puts 1440 into the middle range
      @(posedge i_ref_clk);
      lim_lm   <= 16'd1000;
      lim_mh   <= 16'd3000;
      limit_wr <= 1'b1;
      @(posedge i_ref_clk);
      limit_wr <= 1'b0;
      watch(int'(C1) + 2);
      chk("thr_new_limit", {7'h00, seen_irq}, 8'h01);
      $display("test threshold done");
      wrap_up();
   end
endmodule
`default_nettype wire
